// File: aac_top.sv
// alarm annunciator and panel control with AXI4-Lite register access
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aac_top #(
	parameter int FLASH_HALF = aac_pkg::FLASH_HALF_CYC
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic nrst, // async reset, active low
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	// data link side, from the message decoder on this clock
	input wire aac_pkg::aac_fault_t fault_msg, // decoded fault message
	input wire logic rx_silence, // global alarm silence received, pulse
	input wire logic link_ok, // data link connection healthy
	output logic tx_silence, // request global silence message, pulse
	// key pins, active high
	input wire logic [aac_pkg::NUM_KEYS-1:0] key_pin, // panel/annun keys
	// lamps and relays
	output logic [aac_pkg::NUM_LEDS-1:0] led_grn, // green lamp per pair
	output logic [aac_pkg::NUM_LEDS-1:0] led_yel, // yellow lamp per pair
	output logic [aac_pkg::NUM_LEDS-1:0] led_red, // red lamp per pair
	output logic lamp_warn, // panel yellow warning lamp
	output logic lamp_shut, // panel red shutdown lamp
	output logic horn_relay, // horn relay drive
	output logic eng_run // engine run command
);

	localparam int NP = aac_pkg::NUM_PAIRS;

	initial begin
		if (FLASH_HALF < 1 || FLASH_HALF > 32'h7fff_ffff)
			$error("aac_top: FLASH_HALF out of range");
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic addr_is_cfg(input logic [7:0] a);
		return (a >= aac_pkg::OFS_CFG_BASE) && (a <= aac_pkg::OFS_CFG_LAST);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// keys

	logic [aac_pkg::NUM_KEYS-1:0] key_lvl;
	logic [aac_pkg::NUM_KEYS-1:0] key_press;

	aac_key_sync #(.WIDTH(aac_pkg::NUM_KEYS)) u_keys (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.key_in(key_pin),
		.key_lvl(key_lvl),
		.key_press(key_press)
	);

	wire ack_panel = key_press[aac_pkg::KEY_ACK_PANEL];
	wire ack_annun = key_press[aac_pkg::KEY_ACK_ANNUN];
	wire ack_any = ack_panel | ack_annun;
	wire lamp_test = key_lvl[aac_pkg::KEY_LAMP_TEST];
	wire reset_key = key_press[aac_pkg::KEY_RESET];
	wire remote_start = key_lvl[aac_pkg::KEY_REMOTE];

	////////////////////////////////////////////////////////////////////////
	// registers and bus slave

	logic [31:0] ctrl_q;
	logic [31:0] cfg_q [NP];
	logic aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] status_w;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire wr_cfg = wr_go & addr_is_cfg(awaddr_q) & (awaddr_q[1:0] == 2'b00);
	wire wr_ctrl = wr_go & (awaddr_q == aac_pkg::OFS_CTRL);
	wire wr_ok = wr_cfg | wr_ctrl | (awaddr_q == aac_pkg::OFS_STATUS);
	wire [3:0] wr_idx = awaddr_q[5:2];
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire rd_cfg = addr_is_cfg(s_axi_araddr) & (s_axi_araddr[1:0] == 2'b00);
	wire rd_ctrl = s_axi_araddr == aac_pkg::OFS_CTRL;
	wire rd_stat = s_axi_araddr == aac_pkg::OFS_STATUS;
	wire [31:0] rd_mux = rd_ctrl ? ctrl_q :
		rd_stat ? status_w :
		rd_cfg ? cfg_q[s_axi_araddr[5:2]] : 32'h0000_0000;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= aac_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? aac_pkg::RESP_OKAY : aac_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// pair configuration store: SPN, FMI, trigger type, severity, colours
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= aac_pkg::CTRL_RESET;
			for (int i = 0; i < NP; i++) cfg_q[i] <= aac_pkg::CFG_RESET;
		end else begin
			if (wr_ctrl) ctrl_q <= merge_bytes(ctrl_q, wdata_q, wstrb_q);
			if (wr_cfg) cfg_q[wr_idx] <= merge_bytes(cfg_q[wr_idx], wdata_q,
				wstrb_q);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= aac_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= (rd_ctrl | rd_stat | rd_cfg) ?
					aac_pkg::RESP_OKAY : aac_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event matching and per-pair alarm state

	logic [NP-1:0] warn_act_q, warn_unack_q, shut_lat_q, shut_unack_q;
	logic [NP-1:0] warn_lit_q;
	logic [NP-1:0] hit;

	always_comb begin
		for (int i = 0; i < NP; i++) begin
			hit[i] = fault_msg.valid
				&& fault_msg.spn == cfg_q[i][aac_pkg::CFG_SPN_LSB +: aac_pkg::CFG_SPN_W]
				&& fault_msg.ttype == cfg_q[i][aac_pkg::CFG_TYPE_LSB +: 2]
				&& (cfg_q[i][aac_pkg::CFG_FMI_LSB +: aac_pkg::CFG_FMI_W]
					== aac_pkg::FMI_ANY
				|| fault_msg.fmi
					== cfg_q[i][aac_pkg::CFG_FMI_LSB +: aac_pkg::CFG_FMI_W]);
		end
	end

	logic [NP-1:0] sev_warn, sev_shut;
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			sev_warn[i] = cfg_q[i][aac_pkg::CFG_SEV_WARN_BIT];
			sev_shut[i] = cfg_q[i][aac_pkg::CFG_SEV_SHUT_BIT];
		end
	end

	wire is_warn = ~fault_msg.shutdown;
	wire [NP-1:0] warn_set = hit & sev_warn & {NP{is_warn & fault_msg.active}};
	wire [NP-1:0] warn_clr = hit & {NP{is_warn & ~fault_msg.active}};
	wire [NP-1:0] shut_set = hit & sev_shut &
		{NP{fault_msg.shutdown & fault_msg.active}};
	wire [NP-1:0] warn_new = warn_set & ~warn_act_q;
	wire [NP-1:0] shut_new = shut_set & ~shut_lat_q;
	wire new_event = |{warn_new, shut_new};

	// set wins over acknowledge and reset in the same cycle
	wire [NP-1:0] warn_act_d = (warn_act_q & ~warn_clr) | warn_set;
	wire [NP-1:0] warn_unack_d = (warn_unack_q & ~{NP{ack_any}}) | warn_new;
	// yellow stays lit after a warning goes inactive until acknowledged
	wire [NP-1:0] warn_lit_d = warn_set |
		(warn_lit_q & ~({NP{ack_any}} & ~warn_act_q));
	wire [NP-1:0] shut_lat_d = (shut_lat_q & ~{NP{reset_key}}) | shut_set;
	wire [NP-1:0] shut_unack_d =
		(shut_unack_q & ~{NP{ack_any | reset_key}}) | shut_new;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			warn_act_q <= '0;
			warn_lit_q <= '0;
			warn_unack_q <= '0;
			shut_lat_q <= '0;
			shut_unack_q <= '0;
		end else begin
			warn_act_q <= warn_act_d;
			warn_lit_q <= warn_lit_d;
			warn_unack_q <= warn_unack_d;
			shut_lat_q <= shut_lat_d;
			shut_unack_q <= shut_unack_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flash timebase, horn and engine mode

	logic [31:0] flash_cnt_q;
	logic flash_q;
	logic horn_q;
	aac_pkg::aac_mode_t mode_q;

	wire flash_tick = flash_cnt_q == 32'(FLASH_HALF - 1);
	wire silence = ack_any | rx_silence;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q <= 1'b0;
		end else if (flash_tick) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q <= ~flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) horn_q <= 1'b0;
		else horn_q <= new_event | (horn_q & ~silence);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_q <= aac_pkg::MODE_STOP;
		end else if (key_press[aac_pkg::KEY_STOP]) begin
			mode_q <= aac_pkg::MODE_STOP;
		end else if (key_press[aac_pkg::KEY_RUN]) begin
			mode_q <= aac_pkg::MODE_RUN;
		end else if (key_press[aac_pkg::KEY_AUTO]) begin
			mode_q <= aac_pkg::MODE_AUTO;
		end
	end

	logic run_d;
	always_comb begin
		unique case (mode_q)
			aac_pkg::MODE_STOP: run_d = 1'b0;
			aac_pkg::MODE_RUN: run_d = 1'b1;
			aac_pkg::MODE_AUTO: run_d = remote_start;
			default: run_d = 1'b0;
		endcase
		if (|shut_lat_q) run_d = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// lamp drive

	logic [NP-1:0] col_g, col_y, col_r;
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			col_g[i] = cfg_q[i][aac_pkg::CFG_GRN_BIT];
			col_y[i] = cfg_q[i][aac_pkg::CFG_YEL_BIT];
			col_r[i] = cfg_q[i][aac_pkg::CFG_RED_BIT];
		end
	end

	// flashing while unacknowledged, steady once acknowledged while still lit or latched
	wire [NP-1:0] yel_pair = (warn_unack_q & {NP{flash_q}}) |
		(warn_lit_q & ~warn_unack_q);
	wire [NP-1:0] red_pair = shut_lat_q & (~shut_unack_q | {NP{flash_q}});
	wire [NP-1:0] grn_pair = ~(warn_lit_q | warn_unack_q | shut_lat_q);
	wire any_wu = |warn_unack_q;
	wire any_su = |shut_unack_q;
	wire panel_y = any_wu ? flash_q : |warn_lit_q;
	wire panel_r = any_su ? flash_q : |shut_lat_q;

	wire [aac_pkg::NUM_LEDS-1:0] g_d = lamp_test ? '1 :
		{link_ok, grn_pair & col_g};
	wire [aac_pkg::NUM_LEDS-1:0] y_d = lamp_test ? '1 :
		{1'b0, yel_pair & col_y};
	wire [aac_pkg::NUM_LEDS-1:0] r_d = lamp_test ? '1 :
		{~link_ok, red_pair & col_r};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			led_grn <= '0;
			led_yel <= '0;
			led_red <= '0;
			lamp_warn <= 1'b0;
			lamp_shut <= 1'b0;
			horn_relay <= 1'b0;
			eng_run <= 1'b0;
			tx_silence <= 1'b0;
		end else begin
			led_grn <= g_d;
			led_yel <= y_d;
			led_red <= r_d;
			lamp_warn <= panel_y | lamp_test;
			lamp_shut <= panel_r | lamp_test;
			horn_relay <= horn_q | lamp_test;
			eng_run <= run_d;
			tx_silence <= ack_panel & ctrl_q[aac_pkg::CTRL_SIL_TX_BIT];
		end
	end

	assign status_w = {shut_lat_q, 9'h000, eng_run, link_ok,
		lamp_shut, lamp_warn, horn_q, mode_q};

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_horn_on_event: assert property (@(posedge clk_sys) disable iff (!nrst)
		new_event |=> horn_q) else $error("horn not raised on new event");
	chk_horn_silence: assert property (@(posedge clk_sys) disable iff (!nrst)
		(silence && !new_event) |=> !horn_q) else $error("horn not silenced");
	chk_ack_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
		(ack_any && !new_event) |=> (warn_unack_q == '0) && (shut_unack_q == '0))
		else $error("acknowledge left flags pending");
	chk_shut_latched: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!reset_key && shut_lat_q[0]) |=> shut_lat_q[0])
		else $error("shutdown dropped without reset");
	chk_reset_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
		(reset_key && shut_set == '0) |=> shut_lat_q == '0)
		else $error("reset key did not clear latches");
	chk_red_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		(shut_lat_q == '0 && !lamp_test) |=> !lamp_shut)
		else $error("red lamp lit with no shutdown");
	chk_lamp_test: assert property (@(posedge clk_sys) disable iff (!nrst)
		lamp_test |=> horn_relay && lamp_warn && lamp_shut && (&led_grn))
		else $error("lamp test incomplete");
	chk_stop_key: assert property (@(posedge clk_sys) disable iff (!nrst)
		key_press[aac_pkg::KEY_STOP] |=> ##1 !eng_run)
		else $error("engine not stopped");
	chk_status_pair: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!link_ok && !lamp_test) |=> led_red[aac_pkg::STATUS_PAIR])
		else $error("link fault not shown");
	chk_steady_yel: assert property (@(posedge clk_sys) disable iff (!nrst)
		(warn_act_q != '0 && warn_unack_q == '0 && !lamp_test && !ack_any
			&& warn_clr == '0 && warn_new == '0) |=> lamp_warn)
		else $error("acknowledged warning not steady");

	cov_warn_ack: cover property (@(posedge clk_sys) disable iff (!nrst)
		warn_new != '0 ##[1:1000] ack_any);
	cov_shut_reset: cover property (@(posedge clk_sys) disable iff (!nrst)
		shut_new != '0 ##[1:1000] reset_key);
	cov_auto_run: cover property (@(posedge clk_sys) disable iff (!nrst)
		mode_q == aac_pkg::MODE_AUTO && eng_run);

endmodule // aac_top
`default_nettype wire

// File: aac_pkg.sv
// shared constants and types for the alarm annunciator control block
package aac_pkg;

	localparam int NUM_PAIRS = 16;
	localparam int NUM_LEDS = 17;
	localparam int STATUS_PAIR = 16;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CFG_BASE = 8'h40;
	localparam logic [7:0] OFS_CFG_LAST = 8'h7c;

	// control register fields
	localparam int CTRL_SIL_TX_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// pair configuration word layout
	localparam int CFG_SPN_LSB = 0;
	localparam int CFG_SPN_W = 19;
	localparam int CFG_FMI_LSB = 19;
	localparam int CFG_FMI_W = 5;
	localparam int CFG_TYPE_LSB = 24;
	localparam int CFG_SEV_WARN_BIT = 26;
	localparam int CFG_SEV_SHUT_BIT = 27;
	localparam int CFG_GRN_BIT = 28;
	localparam int CFG_YEL_BIT = 29;
	localparam int CFG_RED_BIT = 30;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [4:0] FMI_ANY = 5'h1f;

	// status register fields
	localparam int ST_MODE_LSB = 0;
	localparam int ST_HORN_BIT = 2;
	localparam int ST_WARN_BIT = 3;
	localparam int ST_SHUT_BIT = 4;
	localparam int ST_LINK_BIT = 5;
	localparam int ST_RUN_BIT = 6;
	localparam int ST_LATCH_LSB = 16;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// flashing: half period of the on/off cycle
	localparam int FLASH_HALF_MS = 250;
	localparam int CLK_HZ = 100_000_000;
	localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

	// key synchroniser bit positions
	localparam int KEY_ACK_PANEL = 0;
	localparam int KEY_ACK_ANNUN = 1;
	localparam int KEY_LAMP_TEST = 2;
	localparam int KEY_RESET = 3;
	localparam int KEY_RUN = 4;
	localparam int KEY_AUTO = 5;
	localparam int KEY_STOP = 6;
	localparam int KEY_REMOTE = 7;
	localparam int NUM_KEYS = 8;

	typedef enum logic [1:0] {
		MODE_STOP = 2'b00,
		MODE_RUN = 2'b01,
		MODE_AUTO = 2'b10
	} aac_mode_t;

	// fault message decoded from the data link
	typedef struct packed {
		logic valid;
		logic [18:0] spn;
		logic [4:0] fmi;
		logic [1:0] ttype;
		logic shutdown;
		logic active;
	} aac_fault_t;

endpackage

// File: aac_key_sync.sv
// two-flop synchroniser with rising-edge pulse for push-button inputs
`timescale 1ns/1ps
`default_nettype none
module aac_key_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [WIDTH-1:0] key_in, // raw key pins, active high
	output logic [WIDTH-1:0] key_lvl, // synchronised level
	output logic [WIDTH-1:0] key_press // one-cycle pulse on press
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	initial begin
		if (WIDTH < 1) $error("aac_key_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= key_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign key_lvl = sync_q;
	assign key_press = sync_q & ~prev_q;

endmodule // aac_key_sync
`default_nettype wire

// File: aac_link_model.sv
// data link partner model: fault messages, silence and link health
`timescale 1ns/1ps
`default_nettype none
module aac_link_model (
	input wire logic clk_sys, // system clock
	output var aac_pkg::aac_fault_t fault_msg, // decoded fault message
	output var logic rx_silence, // silence received, pulse
	output var logic link_ok // link healthy level
);
	initial begin
		fault_msg = '0;
		rx_silence = 1'b0;
		link_ok = 1'b1;
	end
	// one-cycle message; idle fields then show the inverse of the last
	task send(input logic [18:0] s, input logic sd, input logic act);
		fault_msg <= '{valid: 1'b1, spn: s, fmi: 5'h03, ttype: 2'h0,
			shutdown: sd, active: act};
		@(posedge clk_sys);
		fault_msg <= {1'b0, ~fault_msg[27:0]};
	endtask
	task silence();
		rx_silence <= 1'b1;
		@(posedge clk_sys);
		rx_silence <= 1'b0;
	endtask
	task set_link(input logic v);
		link_ok <= v;
	endtask
endmodule // aac_link_model
`default_nettype wire

// File: alarm_annunciator_control_tb.sv
// self-checking bench for the alarm annunciator block
`timescale 1ns/1ps
`default_nettype none
module alarm_annunciator_control_tb;
	localparam logic [1:0] OFF = 2'h0;
	localparam logic [1:0] FL = 2'h1;
	localparam logic [1:0] ST = 2'h2;
	logic clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_silence;
	logic lamp_warn, lamp_shut, horn_relay, eng_run;
	logic [7:0] s_axi_awaddr, s_axi_araddr, key_pin;
	logic [31:0] s_axi_wdata, s_axi_rdata, st;
	logic [31:0] seed = 32'h0000b0aa;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [16:0] led_grn, led_yel, led_red;
	logic [18:0] sp, sx;
	wire logic rx_silence, link_ok;
	wire aac_pkg::aac_fault_t fault_msg;
	int fails = 0, num_checks = 0, txn = 0, t0;
	aac_link_model link_u (.clk_sys, .fault_msg, .rx_silence, .link_ok);
	aac_top #(.FLASH_HALF(4)) dut_u (.clk_sys, .nrst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fault_msg, .rx_silence, .link_ok, .tx_silence, .key_pin, .led_grn,
		.led_yel, .led_red, .lamp_warn, .lamp_shut, .horn_relay, .eng_run);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) txn += (tx_silence === 1'b1);
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] cfg(input logic [18:0] s,
		input logic g, input logic y, input logic rd_en);
		logic [31:0] w;
		w = aac_pkg::CFG_RESET;
		w[aac_pkg::CFG_SPN_LSB +: aac_pkg::CFG_SPN_W] = s;
		w[aac_pkg::CFG_FMI_LSB +: aac_pkg::CFG_FMI_W] = aac_pkg::FMI_ANY;
		w[aac_pkg::CFG_SEV_WARN_BIT] = 1'b1;
		w[aac_pkg::CFG_SEV_SHUT_BIT] = 1'b1;
		w[aac_pkg::CFG_GRN_BIT] = g;
		w[aac_pkg::CFG_YEL_BIT] = y;
		w[aac_pkg::CFG_RED_BIT] = rd_en;
		return w;
	endfunction
	task stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task bad(input string s);
		fails++;
		$display("[FAIL] %0t %s", $time, s);
	endtask
	task chk_b(input logic g, input logic e);
		num_checks++;
		if (g !== e) bad($sformatf("bit got %b exp %b", g, e));
	endtask
	task chk_w(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) bad($sformatf("word got %h exp %h", g, e));
	endtask
	// 16 samples span two flash periods: off, flashing or steady
	task lamp(input int sel, input logic [1:0] e);
		int c;
		logic s;
		c = 0;
		repeat (16) begin
			@(posedge clk_sys);
			s = sel == 0 ? lamp_warn : sel == 1 ? lamp_shut :
				sel == 2 ? led_yel[0] : led_red[0];
			c += (s === 1'b1);
		end
		num_checks++;
		if ((c == 0 ? OFF : c == 16 ? ST : FL) !== e) bad("lamp pattern");
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		while (n < 64) begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		r = s_axi_bresp;
		if (n >= 64) begin
			bad("write hang");
			stop_test();
		end
	endtask
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (n < 64) begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		{st, r} = {s_axi_rdata, s_axi_rresp};
		if (n >= 64) begin
			bad("read hang");
			stop_test();
		end
	endtask
	task press(input int k);
		key_pin[k] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		key_pin[k] <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
	task mode_is(input logic [1:0] e, input logic run);
		rd(aac_pkg::OFS_STATUS);
		chk_w(32'(st[1:0]), 32'(e));
		chk_b(eng_run, run);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, key_pin} = '0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rd(aac_pkg::OFS_CTRL);
		chk_w(st, aac_pkg::CTRL_RESET);
		rd(aac_pkg::OFS_CFG_BASE);
		chk_w(st, aac_pkg::CFG_RESET);
		rd(8'h20);
		chk_w(32'(r), 32'(aac_pkg::RESP_SLVERR));
		wr(aac_pkg::OFS_STATUS, 32'hffff_ffff);
		chk_w(32'(r), 32'(aac_pkg::RESP_OKAY));
		sp = 19'(rnd());
		wr(aac_pkg::OFS_CFG_BASE, cfg(sp, 1'b0, 1'b1, 1'b1));
		wr(aac_pkg::OFS_CFG_BASE + 8'h04, cfg(sp ^ 19'h1, 1'b1, 1'b0, 1'b0));
		wr(aac_pkg::OFS_CFG_LAST, cfg(sp ^ 19'h2, 1'b0, 1'b1, 1'b1));
		rd(aac_pkg::OFS_CFG_LAST);
		chk_w(st, cfg(sp ^ 19'h2, 1'b0, 1'b1, 1'b1));
		chk_b(led_grn[1], 1'b1);
		chk_b(led_red[16], 1'b0);
		link_u.set_link(1'b0);
		repeat (4) @(posedge clk_sys);
		chk_b(led_red[16], 1'b1);
		link_u.set_link(1'b1);
		repeat (6) begin
			sx = 19'(rnd());
			sx[18] = ~sp[18];
			link_u.send(sx, sx[0], 1'b1);
			repeat (3) @(posedge clk_sys);
			chk_b(horn_relay, 1'b0);
		end
		press(aac_pkg::KEY_RUN);
		mode_is(aac_pkg::MODE_RUN, 1'b1);
		press(aac_pkg::KEY_STOP);
		mode_is(aac_pkg::MODE_STOP, 1'b0);
		press(aac_pkg::KEY_AUTO);
		mode_is(aac_pkg::MODE_AUTO, 1'b0);
		key_pin[aac_pkg::KEY_REMOTE] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk_b(eng_run, 1'b1);
		press(aac_pkg::KEY_RUN);
		key_pin[aac_pkg::KEY_REMOTE] <= 1'b0;
		link_u.send(sp, 1'b0, 1'b1);
		repeat (3) @(posedge clk_sys);
		chk_b(horn_relay, 1'b1);
		lamp(2, FL);
		lamp(0, FL);
		repeat (16) begin
			@(posedge clk_sys);
			chk_b(led_yel[0], lamp_warn);
		end
		press(aac_pkg::KEY_ACK_ANNUN);
		chk_b(horn_relay, 1'b0);
		lamp(0, ST);
		lamp(2, ST);
		link_u.send(sp, 1'b0, 1'b0);
		lamp(0, ST);
		press(aac_pkg::KEY_ACK_PANEL);
		lamp(0, OFF);
		wr(aac_pkg::OFS_CTRL, 32'h1);
		link_u.send(sp, 1'b0, 1'b1);
		repeat (3) @(posedge clk_sys);
		t0 = txn;
		press(aac_pkg::KEY_ACK_PANEL);
		chk_b(horn_relay, 1'b0);
		chk_w(32'(txn - t0), 32'h1);
		link_u.send(sp, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys);
		chk_b(horn_relay, 1'b1);
		chk_b(eng_run, 1'b0);
		lamp(3, FL);
		lamp(1, FL);
		link_u.silence();
		repeat (3) @(posedge clk_sys);
		chk_b(horn_relay, 1'b0);
		press(aac_pkg::KEY_ACK_ANNUN);
		lamp(1, ST);
		link_u.send(sp, 1'b1, 1'b0);
		lamp(1, ST);
		rd(aac_pkg::OFS_STATUS);
		chk_b(st[aac_pkg::ST_LATCH_LSB], 1'b1);
		press(aac_pkg::KEY_RESET);
		lamp(1, OFF);
		rd(aac_pkg::OFS_STATUS);
		chk_b(st[aac_pkg::ST_LATCH_LSB], 1'b0);
		link_u.set_link(1'b0);
		key_pin[aac_pkg::KEY_LAMP_TEST] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk_w(32'(led_grn & led_yel & led_red), 32'h1ffff);
		chk_b(horn_relay, 1'b1);
		key_pin[aac_pkg::KEY_LAMP_TEST] <= 1'b0;
		repeat (6) @(posedge clk_sys);
		stop_test();
	end
endmodule // alarm_annunciator_control_tb
`default_nettype wire
